/* core/pse_gm_pkg.sv */
// Purpose: shared constants for the fault status and general mask block
// Assumes: 125 MHz MCLK, eight channels
// Notes: timing counts derived from times in their own units
package pse_gm_pkg;
  localparam int NCH = 8;
  localparam logic [7:0] CMD_GEN_MASK = 8'h17;
  localparam logic [7:0] GEN_MASK_RST = 8'h80;
  localparam int BIT_IRQ_GATE = 7;
  localparam int BIT_WIDE_ACC = 5;
  localparam int BIT_MULTI_SHDN = 4;
  localparam int BIT_CLASS_DELTA = 3;
  localparam int BIT_DETECT_DELTA = 2;
  localparam int CLK_MHZ = 125;
  localparam int OVLD_EXTRA_US = 6000;
  localparam int OVLD_EXTRA_CYC = OVLD_EXTRA_US * CLK_MHZ;
  localparam int LIM_MIN_US = 60000;
  localparam int LIM_MIN_CYC = LIM_MIN_US * CLK_MHZ;
  localparam int LIM_STEP_US = 30000;
  localparam int LIM_STEP_CYC = LIM_STEP_US * CLK_MHZ;
  localparam int CLASS_W = 4;
  localparam int DETECT_W = 3;
endpackage

/* core/pse_fault_status_and_general_mask.sv */
// Purpose: channel power status flags, fault timeouts and general mask register
// Assumes: command port is the decoded byte layer of the serial host interface
// Notes: long counts are parameters so simulation can shorten them
`timescale 1ns/1ps
`default_nettype none
// Function
// (RQ1) timeout faults clear power good and enable
// (RQ2) current limit timeout never below minimum
// (RQ3) four pair cut overload adds about 6 ms
// (RQ4) host reaches mask via command 17h
// (RQ5) mask resets to 80h, all bits writable
// (RQ6) gate bit zero keeps interrupt inactive
// (RQ7) access width bit selects 16 or 8 bit
// (RQ8) shutdown bit selects one or three bit
// (RQ9) delta-only bits report changed results only
module pse_fault_status_and_general_mask
  import pse_gm_pkg::*;
#(
  parameter int OVLD_EXTRA = pse_gm_pkg::OVLD_EXTRA_CYC,
  parameter int LIM_MIN = pse_gm_pkg::LIM_MIN_CYC,
  parameter int LIM_STEP = pse_gm_pkg::LIM_STEP_CYC
)(
  // clock and reset
  input wire logic MCLK,
  input wire logic RESETN,
  // host command port
  input wire logic CMD_VALID,
  input wire logic CMD_WRITE,
  input wire logic [7:0] CMD_CODE,
  input wire logic [7:0] CMD_WDATA,
  output logic [7:0] CMD_RDATA,
  output logic CMD_RVALID,
  // channel fault sources
  input wire logic [pse_gm_pkg::NCH-1:0] OVER_CURRENT,
  input wire logic [1:0] CURRENT_LIMIT_FAULT_TIME,
  input wire logic [pse_gm_pkg::NCH-1:0] OVERLOAD_FAULT_TIME,
  input wire logic [pse_gm_pkg::NCH-1:0] FOUR_PAIR_CUT,
  input wire logic [pse_gm_pkg::NCH-1:0] DISCONNECT_FAULT_TIME,
  input wire logic [pse_gm_pkg::NCH-1:0] STARTUP_FAULT_TIME,
  // power status
  input wire logic [pse_gm_pkg::NCH-1:0] POWER_ON,
  output logic [pse_gm_pkg::NCH-1:0] CHAN_POWER_GOOD_FLAG,
  output logic [pse_gm_pkg::NCH-1:0] CHAN_POWER_ENABLE_FLAG,
  // classification and detection results
  input wire logic [pse_gm_pkg::NCH-1:0] CLASS_DONE,
  input wire logic [pse_gm_pkg::NCH-1:0][pse_gm_pkg::CLASS_W-1:0] CLASS_RESULT,
  input wire logic [pse_gm_pkg::NCH-1:0] DETECT_DONE,
  input wire logic [pse_gm_pkg::NCH-1:0][pse_gm_pkg::DETECT_W-1:0] DETECT_RESULT,
  input wire logic [pse_gm_pkg::NCH-1:0] EVENT_CLEAR,
  output logic [pse_gm_pkg::NCH-1:0] CLASS_EVENT_FLAG,
  output logic [pse_gm_pkg::NCH-1:0] DETECT_EVENT_FLAG,
  // interrupt and mode outputs
  input wire logic IRQ_REQUEST,
  output logic IRQ_N,
  output logic WIDE_ACCESS_SELECT,
  output logic MULTILEVEL_SHUTDOWN_SELECT
);
  import pse_gm_pkg::*;

  function automatic logic [31:0] lim_cycles(input logic [1:0] sel);
    logic [31:0] t;
    t = 32'(LIM_STEP) * (32'(sel) + 32'h1);
    lim_cycles = (t < 32'(LIM_MIN)) ? 32'(LIM_MIN) : t;
  endfunction

  logic [7:0] gen_mask_reg;
  logic [31:0] lim_cnt_reg [NCH];
  logic [31:0] ovl_cnt_reg [NCH];
  logic [NCH-1:0] ovl_run_reg;
  logic [NCH-1:0][CLASS_W-1:0] class_prev_reg;
  logic [NCH-1:0][DETECT_W-1:0] detect_prev_reg;

  wire mask_hit = CMD_VALID && (CMD_CODE == CMD_GEN_MASK); // [RQ4]
  wire mask_wr = mask_hit && CMD_WRITE;
  wire [31:0] lim_target = lim_cycles(CURRENT_LIMIT_FAULT_TIME); // [RQ2]
  wire class_delta_only = gen_mask_reg[BIT_CLASS_DELTA];
  wire detect_delta_only = gen_mask_reg[BIT_DETECT_DELTA];

  logic [NCH-1:0] lim_fault;
  logic [NCH-1:0] ovl_fault;
  logic [NCH-1:0] fault_any;
  logic [NCH-1:0] class_set;
  logic [NCH-1:0] detect_set;

  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      lim_fault[i] = OVER_CURRENT[i] && (lim_cnt_reg[i] >= lim_target - 32'h1); // [RQ2]
      // pcut overload waits the extra delay; plain overload acts at once
      ovl_fault[i] = (OVERLOAD_FAULT_TIME[i] && !FOUR_PAIR_CUT[i])
                  || (ovl_run_reg[i] && ovl_cnt_reg[i] == 32'(OVLD_EXTRA) - 32'h1); // [RQ3]
      fault_any[i] = lim_fault[i] || ovl_fault[i] || DISCONNECT_FAULT_TIME[i]
                  || STARTUP_FAULT_TIME[i];
      class_set[i] = CLASS_DONE[i]
                  && (!class_delta_only || CLASS_RESULT[i] != class_prev_reg[i]); // [RQ9]
      detect_set[i] = DETECT_DONE[i]
                  && (!detect_delta_only || DETECT_RESULT[i] != detect_prev_reg[i]); // [RQ9]
    end
  end

  // mask register and read path
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      gen_mask_reg <= GEN_MASK_RST; // [RQ5]
      CMD_RDATA <= 8'h00;
      CMD_RVALID <= 1'b0;
    end
    else
    begin
      if (mask_wr)
        gen_mask_reg <= CMD_WDATA; // [RQ5]
      CMD_RVALID <= CMD_VALID && !CMD_WRITE;
      // unmapped codes read as zero
      CMD_RDATA <= (mask_hit && !CMD_WRITE) ? gen_mask_reg : 8'h00; // [RQ4]
    end
  end

  // mode outputs and interrupt pin
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      IRQ_N <= 1'b1;
      WIDE_ACCESS_SELECT <= 1'b0;
      MULTILEVEL_SHUTDOWN_SELECT <= 1'b0;
    end
    else
    begin
      // event flags keep updating; only the pin is gated
      IRQ_N <= !(IRQ_REQUEST && gen_mask_reg[BIT_IRQ_GATE]); // [RQ6]
      WIDE_ACCESS_SELECT <= gen_mask_reg[BIT_WIDE_ACC]; // [RQ7]
      MULTILEVEL_SHUTDOWN_SELECT <= gen_mask_reg[BIT_MULTI_SHDN]; // [RQ8]
    end
  end

  // per-channel timers, status and events
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        lim_cnt_reg[i] <= 32'h0;
        ovl_cnt_reg[i] <= 32'h0;
      end
      ovl_run_reg <= '0;
      CHAN_POWER_GOOD_FLAG <= '0;
      CHAN_POWER_ENABLE_FLAG <= '0;
      CLASS_EVENT_FLAG <= '0;
      DETECT_EVENT_FLAG <= '0;
      class_prev_reg <= '0;
      detect_prev_reg <= '0;
    end
    else
    begin
      for (int i = 0; i < NCH; i++)
      begin
        lim_cnt_reg[i] <= (OVER_CURRENT[i] && !lim_fault[i]) ? lim_cnt_reg[i] + 32'h1 : 32'h0;
        if (ovl_fault[i])
          ovl_run_reg[i] <= 1'b0;
        else if (OVERLOAD_FAULT_TIME[i] && FOUR_PAIR_CUT[i])
          ovl_run_reg[i] <= 1'b1; // [RQ3]
        ovl_cnt_reg[i] <= (ovl_run_reg[i] && !ovl_fault[i]) ? ovl_cnt_reg[i] + 32'h1 : 32'h0;
        // fault beats a simultaneous power-on
        if (fault_any[i])
        begin
          CHAN_POWER_GOOD_FLAG[i] <= 1'b0; // [RQ1]
          CHAN_POWER_ENABLE_FLAG[i] <= 1'b0; // [RQ1]
        end
        else if (POWER_ON[i])
        begin
          CHAN_POWER_GOOD_FLAG[i] <= 1'b1;
          CHAN_POWER_ENABLE_FLAG[i] <= 1'b1;
        end
        // set wins over clear
        CLASS_EVENT_FLAG[i] <= class_set[i] || (CLASS_EVENT_FLAG[i] && !EVENT_CLEAR[i]);
        DETECT_EVENT_FLAG[i] <= detect_set[i] || (DETECT_EVENT_FLAG[i] && !EVENT_CLEAR[i]);
        if (CLASS_DONE[i])
          class_prev_reg[i] <= CLASS_RESULT[i];
        if (DETECT_DONE[i])
          detect_prev_reg[i] <= DETECT_RESULT[i];
      end
    end
  end

  a_fault_clears_flags: assert property (@(posedge MCLK) disable iff (!RESETN) // [RQ1]
    |fault_any |=> ((CHAN_POWER_GOOD_FLAG | CHAN_POWER_ENABLE_FLAG) & $past(fault_any)) == '0)
    else $error("fault did not clear power flags");

  a_lim_min_time: assert property (@(posedge MCLK) disable iff (!RESETN) // [RQ2]
    lim_fault[0] |-> lim_cnt_reg[0] >= 32'(LIM_MIN) - 32'h1)
    else $error("current limit fault before minimum time");

  a_ovld_pcut_delay: assert property (@(posedge MCLK) disable iff (!RESETN) // [RQ3]
    (OVERLOAD_FAULT_TIME[0] && FOUR_PAIR_CUT[0] && !ovl_run_reg[0]) |=> !ovl_fault[0] || OVERLOAD_FAULT_TIME[0] && !FOUR_PAIR_CUT[0] || OVLD_EXTRA == 1)
    else $error("pcut overload acted without extra delay");

  a_mask_read_back: assert property (@(posedge MCLK) disable iff (!RESETN) // [RQ4]
    (mask_hit && !CMD_WRITE) |=> CMD_RVALID && CMD_RDATA == $past(gen_mask_reg))
    else $error("mask read returned wrong data");

  a_mask_write_takes: assert property (@(posedge MCLK) disable iff (!RESETN) // [RQ5]
    mask_wr |=> gen_mask_reg == $past(CMD_WDATA))
    else $error("mask write lost");

  a_irq_gate_off: assert property (@(posedge MCLK) disable iff (!RESETN) // [RQ6]
    !gen_mask_reg[BIT_IRQ_GATE] |=> IRQ_N)
    else $error("interrupt asserted while gated");

  a_wide_select: assert property (@(posedge MCLK) disable iff (!RESETN) // [RQ7]
    ##1 WIDE_ACCESS_SELECT == $past(gen_mask_reg[BIT_WIDE_ACC]))
    else $error("access width output stale");

  a_shutdown_select: assert property (@(posedge MCLK) disable iff (!RESETN) // [RQ8]
    ##1 MULTILEVEL_SHUTDOWN_SELECT == $past(gen_mask_reg[BIT_MULTI_SHDN]))
    else $error("shutdown scheme output stale");

  a_class_same_quiet: assert property (@(posedge MCLK) disable iff (!RESETN) // [RQ9]
    (CLASS_DONE[0] && class_delta_only && CLASS_RESULT[0] == class_prev_reg[0]
     && !CLASS_EVENT_FLAG[0]) |=> !CLASS_EVENT_FLAG[0])
    else $error("class event raised for unchanged result");

endmodule // pse_fault_status_and_general_mask
`default_nettype wire

/* bench/host_model.sv */
// Purpose: host side of the byte command port
// Assumes: one byte per command, driven 1 ns after the rising edge
// Notes: answers are sampled once the edge's updates have landed
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock
  input wire logic MCLK,
  // command port
  output logic CMD_VALID,
  output logic CMD_WRITE,
  output logic [7:0] CMD_CODE,
  output logic [7:0] CMD_WDATA,
  input wire logic [7:0] CMD_RDATA,
  input wire logic CMD_RVALID
);
  initial
  begin
    CMD_VALID = 1'b0;
    CMD_WRITE = 1'b0;
    CMD_CODE = 8'h00;
    CMD_WDATA = 8'h00;
  end
  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    @(posedge MCLK);
    #1;
    CMD_VALID = 1'b1;
    CMD_WRITE = 1'b1;
    CMD_CODE = code;
    CMD_WDATA = data;
    @(posedge MCLK);
    #1;
    CMD_VALID = 1'b0;
    CMD_WDATA = ~data;  // stale byte must not look valid
  endtask
  task automatic rd(input logic [7:0] code, output logic [7:0] data, output logic ok);
    int i;
    @(posedge MCLK);
    #1;
    CMD_VALID = 1'b1;
    CMD_WRITE = 1'b0;
    CMD_CODE = code;
    @(posedge MCLK);
    #1;
    CMD_VALID = 1'b0;
    for (i = 0; i < 4 && CMD_RVALID !== 1'b1; i++)
    begin
      @(posedge MCLK);
      #1;
    end
    ok = CMD_RVALID;
    data = CMD_RDATA;
  endtask
endmodule // host_model
`default_nettype wire

/* bench/pse_fault_status_and_general_mask_tb.sv */
// Purpose: self-checking bench for fault status and general mask
// Assumes: fault counts shortened through parameters
// Notes: expectations come from the parameter values set here
`timescale 1ns/1ps
`default_nettype none
module pse_fault_status_and_general_mask_tb;
  import pse_gm_pkg::*;
  logic MCLK = 1'b0, RESETN = 1'b0, v, w, rv, ok, irq = 1'b0, irq_n, wsel, msel;
  logic [7:0] code, wd, rdat, got;
  logic [NCH-1:0] oc = '0, ovl = '0, fpc = '0, dis = '0, st = '0, pon = '0, cd = '0, dd = '0;
  logic [NCH-1:0] ec = '0, pg, pe, cf, df;
  logic [1:0] lsel = 2'h0;
  logic [NCH-1:0][CLASS_W-1:0] cr = '0;
  logic [NCH-1:0][DETECT_W-1:0] dr = '0;
  int n_fail = 0;
  int checked = 0;
  always #4 MCLK = ~MCLK;
  host_model host_model_i (.MCLK(MCLK), .CMD_VALID(v), .CMD_WRITE(w), .CMD_CODE(code),
    .CMD_WDATA(wd), .CMD_RDATA(rdat), .CMD_RVALID(rv));
  pse_fault_status_and_general_mask #(.OVLD_EXTRA(20), .LIM_MIN(30), .LIM_STEP(10))
    pse_fault_status_and_general_mask_i (.MCLK(MCLK), .RESETN(RESETN), .CMD_VALID(v),
    .CMD_WRITE(w), .CMD_CODE(code), .CMD_WDATA(wd), .CMD_RDATA(rdat), .CMD_RVALID(rv),
    .OVER_CURRENT(oc), .CURRENT_LIMIT_FAULT_TIME(lsel), .OVERLOAD_FAULT_TIME(ovl),
    .FOUR_PAIR_CUT(fpc), .DISCONNECT_FAULT_TIME(dis), .STARTUP_FAULT_TIME(st),
    .POWER_ON(pon), .CHAN_POWER_GOOD_FLAG(pg), .CHAN_POWER_ENABLE_FLAG(pe),
    .CLASS_DONE(cd), .CLASS_RESULT(cr), .DETECT_DONE(dd), .DETECT_RESULT(dr),
    .EVENT_CLEAR(ec), .CLASS_EVENT_FLAG(cf), .DETECT_EVENT_FLAG(df), .IRQ_REQUEST(irq),
    .IRQ_N(irq_n), .WIDE_ACCESS_SELECT(wsel), .MULTILEVEL_SHUTDOWN_SELECT(msel));
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", s, e, g);
      n_fail++;
    end
  endtask
  task automatic rdc(input string s, input logic [7:0] c, input logic [7:0] e);
    host_model_i.rd(c, got, ok);
    chk("read answer", 8'h01, {7'h00, ok});
    if (ok !== 1'b1)
      test_done();
    else
      chk(s, e, got);
  endtask
  task automatic t_mask();
    logic [7:0] pat [4] = '{8'hff, 8'h00, 8'h30, 8'ha5};
    rdc("mask reset", CMD_GEN_MASK, GEN_MASK_RST);
    chk("selects reset", 8'h00, {6'h00, wsel, msel});
    foreach (pat[i])
    begin
      host_model_i.wr(CMD_GEN_MASK, pat[i]);
      rdc("mask rw", CMD_GEN_MASK, pat[i]);
      chk("selects", {6'h00, pat[i][5:4]}, {6'h00, wsel, msel});
    end
    host_model_i.wr(8'h18, 8'h00);
    rdc("unmapped read", 8'h18, 8'h00);
    rdc("mask kept", CMD_GEN_MASK, 8'ha5);
  endtask
  task automatic t_irq();
    host_model_i.wr(CMD_GEN_MASK, 8'h80);
    irq = 1'b1;
    tick(3);
    chk("irq gated on", 8'h00, {7'h00, irq_n});
    host_model_i.wr(CMD_GEN_MASK, 8'h00);
    tick(3);
    chk("irq gated off", 8'h01, {7'h00, irq_n});
    irq = 1'b0;
  endtask
  task automatic t_fault();
    pon = '1;
    tick(1);
    pon = '0;
    tick(1);
    chk("power good set", 8'hff, pg);
    dis = 8'h08;
    st = 8'h02;
    ovl = 8'h04;
    tick(1);
    {dis, st, ovl} = '0;
    tick(1);
    chk("good after faults", 8'hf1, pg);
    chk("enable after faults", 8'hf1, pe);
    // channel 0 so the delay assertion sees this pulse
    fpc = 8'h01;
    ovl = 8'h01;
    tick(1);
    ovl = '0;
    tick(19);
    chk("cut overload early", 8'hf1, pg);
    tick(1);
    chk("cut overload late", 8'hf0, pe);
    fpc = '0;
  endtask
  task automatic t_lim();
    int t;
    for (int s = 0; s < 4; s++)
    begin
      t = (10 * (s + 1) > 30) ? 10 * (s + 1) : 30;
      pon = 8'h01;
      tick(1);
      pon = '0;
      lsel = 2'(s);
      oc = 8'h01;
      tick(t - 1);
      chk("limit early", 8'h01, {7'h00, pg[0]});
      tick(1);
      chk("limit late", 8'h00, {7'h00, pe[0]});
      oc = '0;
    end
  endtask
  task automatic do_ev(input logic ec_exp, input logic ed_exp);
    ec = 8'h01;
    tick(1);
    ec = '0;
    cd = 8'h01;
    dd = 8'h01;
    tick(1);
    {cd, dd} = '0;
    tick(1);
    chk("class event", {7'h00, ec_exp}, {7'h00, cf[0]});
    chk("detect event", {7'h00, ed_exp}, {7'h00, df[0]});
  endtask
  initial
  begin
    tick(16);
    RESETN = 1'b1;
    tick(1);
    t_mask();
    t_irq();
    t_fault();
    t_lim();
    host_model_i.wr(CMD_GEN_MASK, 8'h08);
    cr[0] = 4'h5;
    dr[0] = 3'h5;
    do_ev(1'b1, 1'b1);
    do_ev(1'b0, 1'b1);
    host_model_i.wr(CMD_GEN_MASK, 8'h04);
    do_ev(1'b1, 1'b0);
    dr[0] = 3'h2;
    do_ev(1'b1, 1'b1);
    test_done();
  end
endmodule // pse_fault_status_and_general_mask_tb
`default_nettype wire
